//--- alusc_pkg.sv
package alusc_pkg;
	// Register byte offsets on the bus
	localparam logic [7:0] OFF_STATUS  = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h04;
	localparam logic [7:0] OFF_OPA     = 8'h08;
	localparam logic [7:0] OFF_OPB     = 8'h0C;
	localparam logic [7:0] OFF_CMD     = 8'h10;
	localparam logic [7:0] OFF_RES_LO  = 8'h14;
	localparam logic [7:0] OFF_RES_HI  = 8'h18;

	// Status field positions
	localparam int ST_DC     = 8;
	localparam int ST_IPL_HI = 7;
	localparam int ST_IPL_LO = 5;
	localparam int ST_N      = 3;
	localparam int ST_OV     = 2;
	localparam int ST_Z      = 1;
	localparam int ST_C      = 0;

	// Control field positions
	localparam int CT_TOP = 3;
	localparam int CT_PSV = 2;

	// Command field positions
	localparam int CMD_OP_HI = 3;
	localparam int CMD_BYTE  = 4;

	// Reset values and constants
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [2:0]  IPL_MAX   = 3'h7;
	localparam logic [15:0] DIV0_QUOT = 16'hFFFF;
	localparam logic [1:0]  HTRANS_NS = 2'h2;
	localparam logic [23:0] MAP_HIGH  = 24'h000000;

	// Operations of the arithmetic unit
	typedef enum logic [3:0] {
		OP_ADD = 4'b0000,
		OP_SUB = 4'b0001,
		OP_AND = 4'b0010,
		OP_IOR = 4'b0011,
		OP_XOR = 4'b0100,
		OP_SHL = 4'b0101,
		OP_LSR = 4'b0110,
		OP_ASR = 4'b0111,
		OP_MSS = 4'b1000,
		OP_MUU = 4'b1001,
		OP_MSU = 4'b1010,
		OP_MUS = 4'b1011,
		OP_MSL = 4'b1100,
		OP_MUL = 4'b1101,
		OP_MBB = 4'b1110,
		OP_DIV = 4'b1111
	} alusc_op_t;

	// Status flags in register bit order 8..0
	typedef struct packed {
		logic       dc;
		logic [2:0] ipl;
		logic       ra;
		logic       n;
		logic       ov;
		logic       z;
		logic       c;
	} alusc_flags_t;

	// Captured bus address phase
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
	} alusc_aphase_t;
endpackage

//--- alusc_top.sv
`timescale 1ns/1ns
module alusc_top (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        loop_busy_in,
	input  wire logic        top_level_set,
	input  wire logic        nested_irq_block,
	output logic             program_window_enable,
	output logic      [3:0]  priority_level,
	output logic             user_irq_blocked
);

	// Address match against one register offset
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	alusc_pkg::alusc_aphase_t ap_reg, ap_next;
	alusc_pkg::alusc_flags_t  flags_reg, flags_next;
	logic        top_reg, top_next;
	logic        psv_reg, psv_next;
	logic        blk_reg, blk_next;
	logic [15:0] opa_reg, opa_next;
	logic [15:0] opb_reg, opb_next;
	logic [4:0]  cmd_reg, cmd_next;
	logic [15:0] res_lo_reg, res_lo_next;
	logic [15:0] res_hi_reg, res_hi_next;
	logic [31:0] rd_reg, rd_next;
	logic        hready_reg;

	// Arithmetic unit working signals
	alusc_pkg::alusc_op_t op_w;
	logic        byte_w, sub_w, go_w;
	logic [15:0] a_w, b_w, bb_w, res_w, hi_w;
	logic [16:0] sum_w, mx_w, my_w;
	logic [8:0]  sumb_w;
	logic [4:0]  nib_w;
	logic [33:0] prod_w;
	logic        sa_w, sb_w, sr_w, c_w, dc_w, ov_w;
	logic        aff_ar, aff_nz, aff_sh;
	logic        st_wr, ct_wr;

	// Command write in its data phase launches the operation
	assign go_w  = ap_reg.wr && hit(ap_reg.addr, alusc_pkg::OFF_CMD);
	assign st_wr = ap_reg.wr && hit(ap_reg.addr, alusc_pkg::OFF_STATUS);
	assign ct_wr = ap_reg.wr && hit(ap_reg.addr, alusc_pkg::OFF_CONTROL);

	// Operand shaping and result select
	always_comb begin
		op_w   = alusc_pkg::alusc_op_t'(hwdata[alusc_pkg::CMD_OP_HI:0]);
		byte_w = hwdata[alusc_pkg::CMD_BYTE];
		a_w    = byte_w ? {8'h00, opa_reg[7:0]} : opa_reg;
		b_w    = byte_w ? {8'h00, opb_reg[7:0]} : opb_reg;
		sub_w  = (op_w == alusc_pkg::OP_SUB);
		// subtract as add of complement plus one
		bb_w   = sub_w ? ~b_w : b_w;
		sum_w  = {1'b0, a_w} + {1'b0, bb_w} + {16'h0000, sub_w};
		sumb_w = {1'b0, a_w[7:0]} + {1'b0, bb_w[7:0]} + {8'h00, sub_w};
		nib_w  = {1'b0, a_w[3:0]} + {1'b0, bb_w[3:0]} + {4'h0, sub_w};
		sa_w   = byte_w ? a_w[7] : a_w[15];
		sb_w   = byte_w ? bb_w[7] : bb_w[15];
		mx_w   = {1'b0, opa_reg};
		my_w   = {1'b0, opb_reg};
		res_w  = alusc_pkg::RST_WORD;
		hi_w   = alusc_pkg::RST_WORD;
		c_w    = 1'b0;
		dc_w   = 1'b0;
		aff_ar = 1'b0;
		aff_nz = 1'b0;
		aff_sh = 1'b0;
		// sign bit 16 chosen per multiply mode
		case (op_w)
			alusc_pkg::OP_MSS: begin
				mx_w = {opa_reg[15], opa_reg};
				my_w = {opb_reg[15], opb_reg};
			end
			alusc_pkg::OP_MSU: mx_w = {opa_reg[15], opa_reg};
			alusc_pkg::OP_MUS: my_w = {opb_reg[15], opb_reg};
			alusc_pkg::OP_MSL: begin
				mx_w = {opa_reg[15], opa_reg};
				my_w = {12'h000, opb_reg[4:0]};
			end
			alusc_pkg::OP_MUL: my_w = {12'h000, opb_reg[4:0]};
			alusc_pkg::OP_MBB: begin
				mx_w = {9'h000, opa_reg[7:0]};
				my_w = {9'h000, opb_reg[7:0]};
			end
			default: begin
				mx_w = {1'b0, opa_reg};
				my_w = {1'b0, opb_reg};
			end
		endcase
		prod_w = 34'($signed(mx_w) * $signed(my_w));
		case (op_w)
			alusc_pkg::OP_ADD, alusc_pkg::OP_SUB: begin
				res_w  = byte_w ? {8'h00, sumb_w[7:0]} : sum_w[15:0];
				// carry out of the top bit
				c_w    = byte_w ? sumb_w[8] : sum_w[16];
				dc_w   = byte_w ? nib_w[4] : sumb_w[8];
				aff_ar = 1'b1;
			end
			alusc_pkg::OP_AND: begin
				res_w  = a_w & b_w;
				aff_nz = 1'b1;
			end
			alusc_pkg::OP_IOR: begin
				res_w  = a_w | b_w;
				aff_nz = 1'b1;
			end
			alusc_pkg::OP_XOR: begin
				res_w  = a_w ^ b_w;
				aff_nz = 1'b1;
			end
			alusc_pkg::OP_SHL: begin
				res_w  = byte_w ? {8'h00, a_w[6:0], 1'b0}
					: {a_w[14:0], 1'b0};
				c_w    = sa_w;
				aff_sh = 1'b1;
			end
			alusc_pkg::OP_LSR: begin
				res_w  = {1'b0, a_w[15:1]};
				c_w    = a_w[0];
				aff_sh = 1'b1;
			end
			alusc_pkg::OP_ASR: begin
				res_w  = byte_w ? {8'h00, a_w[7], a_w[7:1]}
					: {a_w[15], a_w[15:1]};
				c_w    = a_w[0];
				aff_sh = 1'b1;
			end
			// unsigned divide, remainder to the high word
			alusc_pkg::OP_DIV: begin
				if (opb_reg == alusc_pkg::RST_WORD) begin
					res_w = alusc_pkg::DIV0_QUOT;
					hi_w  = opa_reg;
				end else begin
					res_w = opa_reg / opb_reg;
					hi_w  = opa_reg % opb_reg;
				end
			end
			default: begin
				res_w = prod_w[15:0];
				hi_w  = prod_w[31:16];
			end
		endcase
		sr_w = byte_w ? res_w[7] : res_w[15];
		// same operand signs, differing result sign
		ov_w = (sa_w == sb_w) && (sr_w != sa_w);
	end

	// Next state of registers, flags and bus answer
	always_comb begin
		ap_next     = '0;
		flags_next  = flags_reg;
		top_next    = top_reg;
		psv_next    = psv_reg;
		opa_next    = opa_reg;
		opb_next    = opb_reg;
		cmd_next    = cmd_reg;
		res_lo_next = res_lo_reg;
		res_hi_next = res_hi_reg;
		rd_next     = rd_reg;
		// Upper address must be zero, else the access is dropped
		if (hsel && hready && htrans == alusc_pkg::HTRANS_NS &&
			haddr[31:8] == alusc_pkg::MAP_HIGH) begin
			ap_next.wr   = hwrite;
			ap_next.rd   = !hwrite;
			ap_next.addr = haddr[7:0];
		end
		// Software writes to status
		if (st_wr) begin
			flags_next.dc = hwdata[alusc_pkg::ST_DC];
			flags_next.n  = hwdata[alusc_pkg::ST_N];
			flags_next.ov = hwdata[alusc_pkg::ST_OV];
			flags_next.z  = hwdata[alusc_pkg::ST_Z];
			flags_next.c  = hwdata[alusc_pkg::ST_C];
			// priority bits locked while nesting blocked
			if (!nested_irq_block)
				flags_next.ipl =
					hwdata[alusc_pkg::ST_IPL_HI:alusc_pkg::ST_IPL_LO];
		end
		// loop busy mirrors the sequencer, never software
		flags_next.ra = loop_busy_in;
		// program window enable is plain read/write
		if (ct_wr) begin
			psv_next = hwdata[alusc_pkg::CT_PSV];
			if (!hwdata[alusc_pkg::CT_TOP])
				top_next = 1'b0;
		end
		// hardware set wins over a software clear
		if (top_level_set)
			top_next = 1'b1;
		if (ap_reg.wr && hit(ap_reg.addr, alusc_pkg::OFF_OPA))
			opa_next = hwdata[15:0];
		if (ap_reg.wr && hit(ap_reg.addr, alusc_pkg::OFF_OPB))
			opb_next = hwdata[15:0];
		// results go to the result registers
		if (go_w) begin
			cmd_next    = hwdata[alusc_pkg::CMD_BYTE:0];
			res_lo_next = res_w;
			res_hi_next = hi_w;
			if (aff_ar || aff_sh)
				flags_next.c = c_w;
			if (aff_ar) begin
				flags_next.dc = dc_w;
				flags_next.ov = ov_w;
			end
			if (aff_ar || aff_sh || aff_nz) begin
				flags_next.n = sr_w;
				// zero set or cleared by the result
				flags_next.z = (res_w == alusc_pkg::RST_WORD);
			end
		end
		// level 7 or top bit blocks interrupts
		blk_next = top_next || (flags_next.ipl == alusc_pkg::IPL_MAX);
		// Read data fetched at address phase; upper bits zero
		if (hsel && hready && htrans == alusc_pkg::HTRANS_NS &&
			!hwrite) begin
			rd_next = '0;
			if (haddr[31:8] == alusc_pkg::MAP_HIGH) begin
				if (hit(haddr[7:0], alusc_pkg::OFF_STATUS))
					rd_next[8:0] = flags_reg;
				if (hit(haddr[7:0], alusc_pkg::OFF_CONTROL)) begin
					rd_next[alusc_pkg::CT_TOP] = top_reg;
					rd_next[alusc_pkg::CT_PSV] = psv_reg;
				end
				if (hit(haddr[7:0], alusc_pkg::OFF_OPA))
					rd_next[15:0] = opa_reg;
				if (hit(haddr[7:0], alusc_pkg::OFF_OPB))
					rd_next[15:0] = opb_reg;
				if (hit(haddr[7:0], alusc_pkg::OFF_CMD))
					rd_next[4:0] = cmd_reg;
				if (hit(haddr[7:0], alusc_pkg::OFF_RES_LO))
					rd_next[15:0] = res_lo_reg;
				if (hit(haddr[7:0], alusc_pkg::OFF_RES_HI))
					rd_next[15:0] = res_hi_reg;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ap_reg     <= '0;
			flags_reg  <= '0;
			top_reg    <= 1'b0;
			psv_reg    <= 1'b0;
			blk_reg    <= 1'b0;
			opa_reg    <= alusc_pkg::RST_WORD;
			opb_reg    <= alusc_pkg::RST_WORD;
			cmd_reg    <= '0;
			res_lo_reg <= alusc_pkg::RST_WORD;
			res_hi_reg <= alusc_pkg::RST_WORD;
			rd_reg     <= '0;
			hready_reg <= 1'b0;
		end else begin
			ap_reg     <= ap_next;
			flags_reg  <= flags_next;
			top_reg    <= top_next;
			psv_reg    <= psv_next;
			blk_reg    <= blk_next;
			opa_reg    <= opa_next;
			opb_reg    <= opb_next;
			cmd_reg    <= cmd_next;
			res_lo_reg <= res_lo_next;
			res_hi_reg <= res_hi_next;
			rd_reg     <= rd_next;
			hready_reg <= 1'b1;
		end
	end

	// Ready rises one edge after reset, then zero wait states; always OKAY
	assign hrdata                = rd_reg;
	assign hreadyout             = hready_reg;
	assign hresp                 = 1'b0;
	assign program_window_enable = psv_reg;
	// top bit concatenated above the status bits
	assign priority_level        = {top_reg, flags_reg.ipl};
	assign user_irq_blocked      = blk_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic add_w, sub_wd;
	assign add_w  = go_w && op_w == alusc_pkg::OP_ADD && !byte_w;
	assign sub_wd = go_w && op_w == alusc_pkg::OP_SUB && !byte_w;
	chk_half_carry: assert property (add_w |=> flags_reg.dc ==
		$past(opa_reg[7:0] + 9'(opb_reg[7:0]) > 9'h0FF))
		else $error("half carry wrong on word add");
	chk_level_seven: assert property (
		flags_reg.ipl == alusc_pkg::IPL_MAX |-> user_irq_blocked)
		else $error("level 7 did not block interrupts");
	chk_ipl_locked: assert property (
		st_wr && nested_irq_block |=> $stable(flags_reg.ipl))
		else $error("priority bits written while locked");
	chk_level_top: assert property (top_level_set |=>
		priority_level[3] ##0 user_irq_blocked)
		else $error("top level bit not set");
	chk_loop_busy: assert property (loop_busy_in |=> flags_reg.ra)
		else $error("loop busy not reflected");
	chk_neg_flag: assert property (go_w && aff_nz |=>
		flags_reg.n == res_lo_reg[$past(byte_w) ? 7 : 15])
		else $error("negative flag wrong");
	chk_ovf_flag: assert property (add_w |=> flags_reg.ov ==
		($past(opa_reg[15]) == $past(opb_reg[15]) &&
		res_lo_reg[15] != $past(opa_reg[15])))
		else $error("overflow flag wrong");
	chk_zero_flag: assert property (add_w |=>
		flags_reg.z == (res_lo_reg == alusc_pkg::RST_WORD))
		else $error("zero flag wrong");
	chk_carry_out: assert property (add_w |=> flags_reg.c ==
		$past(opa_reg + 17'(opb_reg) > 17'h0FFFF))
		else $error("carry flag wrong");
	chk_borrow_inv: assert property (sub_wd |=>
		flags_reg.c == $past(opa_reg >= opb_reg))
		else $error("borrow convention wrong");
	chk_top_clear: assert property (ct_wr && !top_level_set &&
		!hwdata[alusc_pkg::CT_TOP] |=> !priority_level[3])
		else $error("top bit not cleared");
	chk_psv_write: assert property (ct_wr |=>
		program_window_enable == $past(hwdata[alusc_pkg::CT_PSV]))
		else $error("program window enable not written");
	chk_reserved_zero: assert property (ap_reg.rd &&
		hit(ap_reg.addr, alusc_pkg::OFF_STATUS) |-> hrdata[31:9] == '0)
		else $error("reserved status bits not zero");
	chk_div_ident: assert property (go_w && op_w == alusc_pkg::OP_DIV &&
		opb_reg != alusc_pkg::RST_WORD |=> 32'(res_lo_reg) *
		32'(opb_reg) + 32'(res_hi_reg) == 32'(opa_reg))
		else $error("division result wrong");
	chk_mul_signed: assert property (go_w && op_w == alusc_pkg::OP_MSS
		|=> $signed({res_hi_reg, res_lo_reg}) == $signed($past(opa_reg)) *
		$signed($past(opb_reg)))
		else $error("signed product wrong");
	chk_mul_noflag: assert property (go_w && op_w == alusc_pkg::OP_MUU &&
		!st_wr |=> flags_reg.c == $past(flags_reg.c) &&
		flags_reg.z == $past(flags_reg.z))
		else $error("multiply changed flags");

	cov_add_carry: cover property (add_w ##1 flags_reg.c);
	cov_div_zero: cover property (go_w && op_w == alusc_pkg::OP_DIV &&
		opb_reg == alusc_pkg::RST_WORD);
	cov_irq_block: cover property (top_level_set ##1 ct_wr ##1
		!user_irq_blocked);
endmodule

//--- alusc_seq_model.sv
`timescale 1ns/1ns
// Sequencer stand-in: repeat loop, priority raise, nesting block
module alusc_seq_model (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       loop_go,
	input  wire logic [7:0] loop_len,
	input  wire logic       raise_go,
	input  wire logic       nest_req,
	output logic            loop_busy_in,
	output logic            top_level_set,
	output logic            nested_irq_block
);
	logic [7:0] left_reg;

	// Loop counter runs down; busy while any iterations remain
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			left_reg         <= 8'h00;
			top_level_set    <= 1'b0;
			nested_irq_block <= 1'b0;
		end else begin
			if (loop_go)
				left_reg <= loop_len;
			else if (left_reg != 8'h00)
				left_reg <= left_reg - 8'h01;
			// Raise copies raise_go one cycle late; the testbench pulses it, so a held level cannot mask a clear
			top_level_set    <= raise_go;
			nested_irq_block <= nest_req;
		end
	end

	// Busy is a level, the way a repeat loop reports it
	assign loop_busy_in = (left_reg != 8'h00);
endmodule

//--- cpu_alu_status_and_control_tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("Error t=%0t got %h exp %h", $time, (g), (e)); \
	end \
end

module cpu_alu_status_and_control_tb_top;
	logic                   mclk;
	logic                   reset_n;
	logic                   hsel;
	logic [31:0]            haddr;
	logic [1:0]             htrans;
	logic                   hwrite;
	logic [2:0]             hsize;
	logic [31:0]            hwdata;
	logic [31:0]            hrdata;
	logic                   hreadyout;
	logic                   hresp;
	logic                   loop_busy_in;
	logic                   top_level_set;
	logic                   nested_irq_block;
	logic                   program_window_enable;
	logic [3:0]             priority_level;
	logic                   user_irq_blocked;
	logic                   loop_go;
	logic [7:0]             loop_len;
	logic                   raise_go;
	logic                   nest_req;
	int                     mismatches;
	int                     checks_done;
	alusc_pkg::alusc_flags_t e_fl;
	logic [15:0]            e_lo;
	logic [15:0]            e_hi;
	logic [31:0]            rd;
	logic [3:0]             op;
	logic                   by;
	logic [15:0]            a;
	logic [15:0]            b;
	logic [15:0]            tbl [4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};

	alusc_top dut_u (
		.mclk                  (mclk),
		.reset_n               (reset_n),
		.hsel                  (hsel),
		.haddr                 (haddr),
		.htrans                (htrans),
		.hwrite                (hwrite),
		.hsize                 (hsize),
		.hwdata                (hwdata),
		.hready                (hreadyout),
		.hrdata                (hrdata),
		.hreadyout             (hreadyout),
		.hresp                 (hresp),
		.loop_busy_in          (loop_busy_in),
		.top_level_set         (top_level_set),
		.nested_irq_block      (nested_irq_block),
		.program_window_enable (program_window_enable),
		.priority_level        (priority_level),
		.user_irq_blocked      (user_irq_blocked)
	);

	alusc_seq_model seq_u (
		.mclk             (mclk),
		.reset_n          (reset_n),
		.loop_go          (loop_go),
		.loop_len         (loop_len),
		.raise_go         (raise_go),
		.nest_req         (nest_req),
		.loop_busy_in     (loop_busy_in),
		.top_level_set    (top_level_set),
		.nested_irq_block (nested_irq_block)
	);

	// Free-running 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic results();
		$display("Counts: checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Bounded wait for ready; a stuck slave ends the run. Ready and read
	// data are taken before the edge so a flop launched there cannot race
	task automatic wait_rdy();
		int   n;
		logic rdy;
		n = 0;
		do begin
			@(negedge mclk);
			rdy = hreadyout;
			rd  = hrdata;
			@(posedge mclk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (rdy !== 1'b1) begin
			mismatches++;
			$display("Error t=%0t bus wait timed out", $time);
			results();
		end
	endtask

	// Single word transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, ad};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	task automatic rchk(input logic [7:0] ad, input logic [15:0] e);
		xfer(1'b0, ad, 32'h00000000);
		`CHK(rd, {16'h0000, e})
	endtask

	// Reference arithmetic; flags left alone where an op does not touch them
	task automatic calc(input logic [3:0] o4, input logic bm,
		input logic [15:0] x16, input logic [15:0] y16);
		logic [16:0] m, bb, s, h, r, o;
		int          w;
		longint      x, y, p;
		w  = bm ? 8 : 16;
		m  = (17'h1 << w) - 17'h1;
		bb = (o4 == 4'h1) ? (~{1'b0, y16} & m) : ({1'b0, y16} & m);
		s  = ({1'b0, x16} & m) + bb + o4[0];
		h  = ({1'b0, x16} & (m >> (w / 2))) + (bb & (m >> (w / 2))) + o4[0];
		case (o4)
			4'h0, 4'h1: r = s & m;
			4'h2: r = x16 & y16 & m;
			4'h3: r = (x16 | y16) & m;
			4'h4: r = (x16 ^ y16) & m;
			4'h5: r = (x16 << 1) & m;
			4'h6: r = (x16 & m) >> 1;
			4'h7: r = ((x16 & m) >> 1) | (x16 & (m ^ (m >> 1)));
			default: r = 17'h00000;
		endcase
		o = ({1'b0, x16} ^ r) & (bb ^ r);
		if (o4 < 4'h8) begin
			e_lo = r[15:0];
			if (o4 < 4'h2) begin
				e_fl.c  = s[w];
				e_fl.dc = h[w / 2];
				e_fl.ov = o[w - 1];
			end
			if (o4 > 4'h4)
				e_fl.c = (o4 == 4'h5) ? x16[w - 1] : x16[0];
			e_fl.n = r[w - 1];
			e_fl.z = (r == 17'h00000);
		end else begin
			x = (o4 == 8 || o4 == 10 || o4 == 12) ?
				longint'($signed(x16)) : longint'(x16);
			y = (o4 == 8 || o4 == 11) ? longint'($signed(y16)) : longint'(y16);
			if (o4 > 4'hB)
				y = longint'(y16[4:0]);
			if (o4 == 4'hE) begin
				x = longint'(x16[7:0]);
				y = longint'(y16[7:0]);
			end
			p    = x * y;
			e_lo = p[15:0];
			e_hi = p[31:16];
			if (o4 == 4'hF) begin
				e_lo = (y16 == 16'h0000) ? 16'hFFFF : x16 / y16;
				e_hi = (y16 == 16'h0000) ? x16 : x16 % y16;
			end
		end
	endtask

	// Main sequence
	initial begin
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		loop_go = 1'b0;
		loop_len = 8'h00;
		raise_go = 1'b0;
		nest_req = 1'b0;
		mismatches = 0;
		checks_done = 0;
		e_fl = '0;
		void'($urandom(48813));
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		`CHK(hreadyout, 1'b0)
		`CHK(priority_level, 4'h0)
		`CHK(hresp, 1'b0)
		rchk(alusc_pkg::OFF_STATUS, 16'h0000);
		rchk(alusc_pkg::OFF_CONTROL, 16'h0000);
		xfer(1'b1, 8'h1C, 32'hFFFFFFFF);
		rchk(8'h1C, 16'h0000);
		`CHK(hreadyout, 1'b1)
		$display("Test reset done");

		// Every op once on corner operands, then random ones
		for (int i = 0; i < 80; i++) begin
			op = (i < 16) ? i[3:0] : 4'($urandom);
			by = 1'($urandom);
			a  = (i < 16) ? tbl[i % 4] : 16'($urandom);
			b  = (i < 16) ? tbl[(i / 4) % 4] : 16'($urandom);
			xfer(1'b1, alusc_pkg::OFF_OPA, {16'h0000, a});
			xfer(1'b1, alusc_pkg::OFF_OPB, {16'h0000, b});
			xfer(1'b1, alusc_pkg::OFF_CMD, {27'h0000000, by, op});
			calc(op, by, a, b);
			rchk(alusc_pkg::OFF_CMD, {11'h000, by, op});
			rchk(alusc_pkg::OFF_RES_LO, e_lo);
			rchk(alusc_pkg::OFF_STATUS, {7'h00, e_fl});
			if (op > 4'h7)
				rchk(alusc_pkg::OFF_RES_HI, e_hi);
		end
		$display("Test arithmetic done");

		xfer(1'b1, alusc_pkg::OFF_STATUS, 32'hFFFFFFFF);
		rchk(alusc_pkg::OFF_STATUS, 16'h01EF);
		`CHK(priority_level, 4'h7)
		`CHK(user_irq_blocked, 1'b1)
		nest_req <= 1'b1;
		repeat (2) @(posedge mclk);
		xfer(1'b1, alusc_pkg::OFF_STATUS, 32'h00000000);
		rchk(alusc_pkg::OFF_STATUS, 16'h00E0);
		nest_req <= 1'b0;
		repeat (2) @(posedge mclk);
		xfer(1'b1, alusc_pkg::OFF_STATUS, 32'h00000040);
		rchk(alusc_pkg::OFF_STATUS, 16'h0040);
		`CHK(user_irq_blocked, 1'b0)
		$display("Test priority status done");

		xfer(1'b1, alusc_pkg::OFF_CONTROL, 32'hFFFFFFFF);
		rchk(alusc_pkg::OFF_CONTROL, 16'h0004);
		`CHK(program_window_enable, 1'b1)
		raise_go <= 1'b1;
		@(posedge mclk);
		raise_go <= 1'b0;
		repeat (3) @(posedge mclk);
		rchk(alusc_pkg::OFF_CONTROL, 16'h000C);
		`CHK(priority_level, 4'hA)
		`CHK(user_irq_blocked, 1'b1)
		xfer(1'b1, alusc_pkg::OFF_CONTROL, 32'h00000000);
		rchk(alusc_pkg::OFF_CONTROL, 16'h0000);
		`CHK(program_window_enable, 1'b0)
		`CHK(priority_level, 4'h2)
		$display("Test control done");

		loop_len <= 8'(30 + $urandom % 20);
		loop_go  <= 1'b1;
		@(posedge mclk);
		loop_go <= 1'b0;
		repeat (2) @(posedge mclk);
		rchk(alusc_pkg::OFF_STATUS, 16'h0050);
		xfer(1'b1, alusc_pkg::OFF_STATUS, 32'h00000040);
		rchk(alusc_pkg::OFF_STATUS, 16'h0050);
		repeat (60) @(posedge mclk);
		rchk(alusc_pkg::OFF_STATUS, 16'h0040);
		$display("Test loop flag done");
		results();
	end
endmodule
